// ==== verilog/fcs_regs.vh ====
// Fault supervisor constants: register offsets, fields, codes, timing
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
`define FCS_OFF_CTRL      4'h0
`define FCS_OFF_FAULT     4'h4
`define FCS_OFF_STATUS    4'h8
`define FCS_OFF_DISP      4'hC
`define FCS_CTRL_KICK     0
`define FCS_CTRL_TKEY     1
`define FCS_CTRL_SHOW     2
`define FCS_CTRL_DEFAULTS 3
`define FCS_CTRL_RAMFAIL  4
`define FCS_CTRL_NVFAIL   5
`define FCS_CTRL_ADCFAIL  6
`define FCS_CODE_RAM      4'h1
`define FCS_CODE_NV       4'h2
`define FCS_CODE_ADC      4'h3
`define FCS_CODE_KEY      4'h8
`define FCS_CODE_FF       4'h9
`define FCS_CODE_WDOG     4'hA
`define FCS_CODE_BADOP    4'hB
`define FCS_CODE_RSVD     4'hC
`define FCS_CLK_HZ        10000000
`define FCS_KEY_SEC       30
`define FCS_KEY_CYC       (`FCS_CLK_HZ * `FCS_KEY_SEC)
`define FCS_WDOG_CYC      1000000
`define FCS_RESET_CYC     16
`endif

// ==== verilog/fcs_supervisor.v ====
// Fault code supervisor with AXI4-Lite register access
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "fcs_regs.vh"
module fcs_supervisor #(
    parameter KEY_CYC   = `FCS_KEY_CYC,
    parameter WDOG_CYC  = `FCS_WDOG_CYC,
    parameter RESET_CYC = `FCS_RESET_CYC
)(
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        grid_fault_first,
    input  wire        grid_fault_second,
    input  wire        fil_fault_first,
    input  wire        fil_fault_second,
    input  wire        degas_fault,
    input  wire        hv_sense_first,
    input  wire        hv_sense_second,
    input  wire        ion_gauge_first_on,
    input  wire        ion_gauge_second_on,
    input  wire        key_pressed,
    input  wire        opcode_fetch,
    input  wire [7:0]  opcode,
    input  wire        opcode_invalid,
    output reg         trouble_lamp,
    output wire        gauges_off,
    output wire        relays_off,
    output reg  [3:0]  right_display,
    output reg         display_valid,
    output wire        halted,
    output wire        cpu_reset,
    output reg         defaults_pulse
);
    localparam ST_RUN   = 2'd0;
    localparam ST_RESET = 2'd1;
    localparam ST_HALT  = 2'd2;

    reg [1:0]  state_r;
    reg [3:0]  halt_code_r;
    reg [3:0]  last_code_r;
    reg        restart_lamp_r;
    reg        nv_fault_r;
    reg [31:0] key_cnt_r;
    reg [31:0] wdog_cnt_r;
    reg [31:0] rst_cnt_r;
    reg        show_r;
    reg        awhit_r;
    reg        whit_r;
    reg [3:0]  awaddr_r;
    reg [31:0] wdata_r;
    reg        bvalid_r;
    reg        rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0]  bresp_r;
    reg [1:0]  rresp_r;

    wire [6:0] warn_vec;
    wire       warn_any;
    reg  [3:0] warn_code;
    wire       wr_go;
    wire       ctl_wr;
    wire       run;
    wire       key_trip;
    wire       wdog_trip;
    wire       op_ff;
    wire       op_bad;
    wire       hv_first;
    wire       hv_second;

    assign run       = (state_r == ST_RUN);
    assign hv_first  = hv_sense_first & ~ion_gauge_first_on;
    assign hv_second = hv_sense_second & ~ion_gauge_second_on;
    // Live warnings; lamp follows them so it drops when cause is gone
    assign warn_vec  = {hv_second, hv_first, degas_fault, fil_fault_second,
                        fil_fault_first, grid_fault_second, grid_fault_first};
    assign warn_any  = |warn_vec;
    assign key_trip  = run & key_pressed & (key_cnt_r >= KEY_CYC - 1);
    assign wdog_trip = run & (wdog_cnt_r >= WDOG_CYC - 1);
    assign op_ff     = run & opcode_fetch & (opcode == 8'hFF);
    assign op_bad    = run & opcode_fetch & opcode_invalid & (opcode != 8'hFF);

    // Lowest-numbered active warning code
    always @*
    begin
        warn_code = 4'h0;
        if (grid_fault_first)       warn_code = 4'h4;
        else if (grid_fault_second) warn_code = 4'h5;
        else if (fil_fault_first)   warn_code = 4'h6;
        else if (fil_fault_second)  warn_code = 4'h7;
        else if (degas_fault)       warn_code = 4'hD;
        else if (hv_first)          warn_code = 4'hE;
        else if (hv_second)         warn_code = 4'hF;
    end

    // AXI4-Lite handshake outputs of both channels, and the write channel
    assign s_axi_awready = ~awhit_r & ~bvalid_r;
    assign s_axi_wready  = ~whit_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign wr_go  = awhit_r & whit_r & ~bvalid_r;
    assign ctl_wr = wr_go & (awaddr_r == `FCS_OFF_CTRL) & run;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awhit_r  <= 1'b0;
            whit_r   <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r  <= 32'h00000000;
            bvalid_r <= 1'b0;
            bresp_r  <= 2'b00;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awhit_r  <= 1'b1;
                awaddr_r <= s_axi_awaddr[3:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                whit_r  <= 1'b1;
                wdata_r <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                          {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
            end
            if (wr_go)
            begin
                awhit_r  <= 1'b0;
                whit_r   <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= (awaddr_r == `FCS_OFF_CTRL) ? 2'b00 : 2'b10;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    // AXI4-Lite read channel
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rresp_r  <= 2'b00;
            if (s_axi_araddr[3:0] == `FCS_OFF_CTRL)
                rdata_r <= {31'h0, show_r};
            else if (s_axi_araddr[3:0] == `FCS_OFF_FAULT)
                rdata_r <= {25'h0, warn_vec};
            else if (s_axi_araddr[3:0] == `FCS_OFF_STATUS)
                rdata_r <= {20'h00000, nv_fault_r, restart_lamp_r, state_r,
                            halt_code_r, last_code_r};
            else if (s_axi_araddr[3:0] == `FCS_OFF_DISP)
                rdata_r <= {27'h0, display_valid, right_display};
            else
            begin
                rdata_r <= 32'h00000000;
                rresp_r <= 2'b10;
            end
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
    end

    // Supervisor state: run, forced restart, latched halt
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r        <= ST_RUN;
            halt_code_r    <= 4'h0;
            last_code_r    <= 4'h0;
            restart_lamp_r <= 1'b0;
            nv_fault_r     <= 1'b0;
            key_cnt_r      <= 32'h00000000;
            wdog_cnt_r     <= 32'h00000000;
            rst_cnt_r      <= 32'h00000000;
            show_r         <= 1'b0;
            defaults_pulse <= 1'b0;
        end
        else
        begin
            defaults_pulse <= 1'b0;
            key_cnt_r <= (run && key_pressed && !key_trip) ? key_cnt_r + 32'h1 : 32'h0;
            case (state_r)
            ST_RUN:
            begin
                wdog_cnt_r <= (ctl_wr && wdata_r[`FCS_CTRL_KICK]) ? 32'h0
                              : wdog_cnt_r + 32'h1;
                if (ctl_wr)
                begin
                    show_r <= wdata_r[`FCS_CTRL_SHOW];
                    if (wdata_r[`FCS_CTRL_NVFAIL])
                        nv_fault_r <= 1'b1;
                    else if (wdata_r[`FCS_CTRL_DEFAULTS])
                    begin
                        nv_fault_r     <= 1'b0;
                        defaults_pulse <= 1'b1;
                    end
                    if (wdata_r[`FCS_CTRL_TKEY] && !(op_ff || op_bad || wdog_trip))
                        restart_lamp_r <= 1'b0;
                end
                // Halting faults win over restarts
                if (ctl_wr && wdata_r[`FCS_CTRL_RAMFAIL])
                begin
                    state_r     <= ST_HALT;
                    halt_code_r <= `FCS_CODE_RAM;
                end
                else if (ctl_wr && wdata_r[`FCS_CTRL_ADCFAIL])
                begin
                    state_r     <= ST_HALT;
                    halt_code_r <= `FCS_CODE_ADC;
                end
                else if (key_trip)
                begin
                    state_r     <= ST_HALT;
                    halt_code_r <= `FCS_CODE_KEY;
                end
                else if (op_ff || op_bad || wdog_trip)
                begin
                    state_r        <= ST_RESET;
                    restart_lamp_r <= 1'b1;
                    rst_cnt_r      <= 32'h0;
                    last_code_r    <= op_ff ? `FCS_CODE_FF
                                    : op_bad ? `FCS_CODE_BADOP
                                    : `FCS_CODE_WDOG;
                end
            end
            ST_RESET:
            begin
                wdog_cnt_r <= 32'h0;
                show_r     <= 1'b0;
                rst_cnt_r  <= rst_cnt_r + 32'h1;
                if (rst_cnt_r >= RESET_CYC - 1)
                    state_r <= ST_RUN;
            end
            default:
            begin
                wdog_cnt_r <= 32'h0;
                if (halt_code_r == `FCS_CODE_RSVD)
                    halt_code_r <= 4'h0;
            end
            endcase
        end
    end

    assign halted     = (state_r == ST_HALT);
    assign cpu_reset  = (state_r == ST_RESET);
    assign gauges_off = ~run;
    assign relays_off = ~run;

    // Lamp and right display
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trouble_lamp  <= 1'b0;
            right_display <= 4'h0;
            display_valid <= 1'b0;
        end
        else
        begin
            trouble_lamp <= halted | restart_lamp_r | nv_fault_r | warn_any;
            if (halted)
            begin
                right_display <= halt_code_r;
                display_valid <= (halt_code_r != `FCS_CODE_RSVD);
            end
            else if (show_r && restart_lamp_r)
            begin
                right_display <= last_code_r;
                display_valid <= 1'b1;
            end
            else if (show_r && nv_fault_r)
            begin
                right_display <= `FCS_CODE_NV;
                display_valid <= 1'b1;
            end
            else if (show_r && warn_any)
            begin
                right_display <= warn_code;
                display_valid <= 1'b1;
            end
            else
            begin
                right_display <= 4'h0;
                display_valid <= 1'b0;
            end
        end
    end
endmodule // fcs_supervisor

// ==== tb/fcs_sup_assertions.sv ====
// Port checker for the fault code supervisor
`timescale 1ns/1ps
module fcs_sup_chk #(
    parameter KEY_CYC   = 50,
    parameter RESET_CYC = 16
)(
    input wire       aclk,
    input wire       aresetn,
    input wire       grid_fault_first,
    input wire       grid_fault_second,
    input wire       fil_fault_first,
    input wire       fil_fault_second,
    input wire       degas_fault,
    input wire       hv_sense_first,
    input wire       hv_sense_second,
    input wire       ion_gauge_first_on,
    input wire       ion_gauge_second_on,
    input wire       key_pressed,
    input wire       opcode_fetch,
    input wire [7:0] opcode,
    input wire       trouble_lamp,
    input wire       gauges_off,
    input wire       relays_off,
    input wire [3:0] right_display,
    input wire       display_valid,
    input wire       halted,
    input wire       cpu_reset
);
    wire       warn_any = grid_fault_first | grid_fault_second | fil_fault_first
        | fil_fault_second | degas_fault | (hv_sense_first & ~ion_gauge_first_on)
        | (hv_sense_second & ~ion_gauge_second_on);
    reg [31:0] key_r;
    reg [7:0]  rst_r;
    // Held-key and restart-length counters
    always @(posedge aclk)
    begin
        key_r <= (!aresetn || !key_pressed || cpu_reset) ? 32'h0 : key_r + 32'h1;
        rst_r <= (!aresetn || !cpu_reset) ? 8'h0 : rst_r + 8'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_halt_out; halted |-> gauges_off && relays_off; endproperty
    a_halt_out: assert property (p_halt_out) else $error("outputs live in halt");
    property p_halt_show; halted |-> ##[0:2] trouble_lamp && display_valid; endproperty
    a_halt_show: assert property (p_halt_show) else $error("halt not shown");
    property p_halt_hold; halted |=> halted; endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt left");
    property p_warn_lamp; warn_any |=> trouble_lamp; endproperty
    a_warn_lamp: assert property (p_warn_lamp) else $error("warning lamp off");
    property p_warn_run; warn_any && !halted && !cpu_reset |-> !gauges_off && !relays_off;
    endproperty
    a_warn_run: assert property (p_warn_run) else $error("warning stopped run");
    property p_rst_out; cpu_reset |-> gauges_off && relays_off; endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs live in restart");
    property p_rst_len; $fell(cpu_reset) |-> rst_r == RESET_CYC; endproperty
    a_rst_len: assert property (p_rst_len) else $error("restart length wrong");
    property p_ff; opcode_fetch && opcode == 8'hFF && !halted && !cpu_reset |-> ##[1:2] cpu_reset;
    endproperty
    a_ff: assert property (p_ff) else $error("no restart on FF fetch");
    property p_key; key_r == KEY_CYC - 1 && key_pressed && !halted && !cpu_reset
        |-> ##1 halted ##1 right_display == 4'h8;
    endproperty
    a_key: assert property (p_key) else $error("held key not halted");
    property p_rst_lamp; $fell(cpu_reset) |-> trouble_lamp; endproperty
    a_rst_lamp: assert property (p_rst_lamp) else $error("lamp off after restart");
    property p_no12; display_valid |-> right_display != 4'hC; endproperty
    a_no12: assert property (p_no12) else $error("reserved code shown");
    c_halt: cover property (halted);
    c_rst: cover property ($fell(cpu_reset));
    c_warn: cover property (warn_any && display_valid);
endmodule // fcs_sup_chk
bind fcs_supervisor fcs_sup_chk #(.KEY_CYC(KEY_CYC), .RESET_CYC(RESET_CYC)) u_chk (.*);

// ==== tb/fcs_panel_model.sv ====
// Front panel and gauge circuit model driving the supervisor inputs
`timescale 1ns/1ps
module fcs_panel_model (
    input  wire       aclk,
    output wire       grid_fault_first,
    output wire       grid_fault_second,
    output wire       fil_fault_first,
    output wire       fil_fault_second,
    output wire       degas_fault,
    output wire       hv_sense_first,
    output wire       hv_sense_second,
    output wire       ion_gauge_first_on,
    output wire       ion_gauge_second_on,
    output wire       key_pressed,
    output reg        opcode_fetch = 1'b0,
    output reg  [7:0] opcode = 8'h3C,
    output reg        opcode_invalid = 1'b0
);
    reg [9:0] lv_r = 10'h0;
    reg [7:0] op_q = 8'h00;
    reg       inv_q = 1'b0;
    reg       go = 1'b0;
    // Fault levels, gauge states and held key
    assign {key_pressed, ion_gauge_second_on, ion_gauge_first_on, hv_sense_second,
        hv_sense_first, degas_fault, fil_fault_second, fil_fault_first,
        grid_fault_second, grid_fault_first} = lv_r;
    // Idle opcode and opcode_invalid lines toggle under a low opcode_fetch so no stale opcode lingers
    always @(posedge aclk)
    begin
        opcode_fetch <= go;
        opcode <= go ? op_q : ~opcode;
        opcode_invalid <= go ? inv_q : ~opcode_invalid;
        go <= 1'b0;
    end
    task lines(input [9:0] v);
        @(posedge aclk);
        lv_r <= v;
    endtask
    task fetch(input [7:0] op, input inv);
        @(negedge aclk);
        op_q = op;
        inv_q = inv;
        go = 1'b1;
        @(posedge aclk);
    endtask
endmodule // fcs_panel_model

// ==== tb/fcs_supervisor_tb.sv ====
// Self-checking bench for the fault code supervisor
`timescale 1ns/1ps
`include "fcs_regs.vh"
module fcs_supervisor_tb;
    localparam KEY = 50;
    logic aclk = 0, aresetn = 0, def_seen = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, rv;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [1:0] rs;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire grid_fault_first, grid_fault_second, fil_fault_first, fil_fault_second;
    wire degas_fault, hv_sense_first, hv_sense_second, ion_gauge_first_on;
    wire ion_gauge_second_on, key_pressed, opcode_fetch, opcode_invalid;
    wire [7:0] opcode;
    wire trouble_lamp, gauges_off, relays_off, display_valid, halted, cpu_reset;
    wire defaults_pulse;
    wire [3:0] right_display;
    int err_total = 0, cmp_count = 0, cyc = 0, i;
    logic [3:0] wc[7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hD, 4'hE, 4'hF};
    logic [3:0] rc[3] = '{4'h9, 4'hB, 4'hA};
    logic [3:0] hc[3] = '{4'h1, 4'h3, 4'h8};
    always #50 aclk = ~aclk;
    fcs_supervisor #(.KEY_CYC(KEY), .WDOG_CYC(200)) uut (.*);
    fcs_panel_model pm (.*);
    task test_done;
        if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc++;
        if (defaults_pulse) def_seen <= 1;
        if (cyc == 5000)
        begin
            err_total++;
            test_done;
        end
    end
    task chk(input [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input [31:0] a, d);
        logic aw, w, b;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(negedge aclk);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
        end while (!b);
        s_axi_bready <= 0;
    endtask
    task rd(input [31:0] a);
        logic ar, r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
        begin
            @(negedge aclk);
            ar = s_axi_arready;
            r = s_axi_rvalid;
            rv = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 0;
        end while (!r);
        s_axi_rready <= 0;
    endtask
    task rst;
        @(posedge aclk);
        aresetn <= 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1;
    endtask
    task wait_rst(input logic v);
        for (i = 0; i < 400 && cpu_reset !== v; i++) @(negedge aclk);
        @(posedge aclk);
    endtask
    initial
    begin
        rst;
        rd(`FCS_OFF_STATUS);
        chk(rv[9:0], 10'h000);
        rd(32'h6);
        chk(rs, 2'h2);
        wr(`FCS_OFF_FAULT, 32'h1);
        chk(rs, 2'h2);
        for (int k = 0; k < 7; k++)
        begin
            pm.lines(10'h1 << k);
            wr(`FCS_OFF_CTRL, 32'h5);
            chk({trouble_lamp, gauges_off}, 2'h2);
            rd(`FCS_OFF_FAULT);
            chk(rv, 32'h1 << k);
            rd(`FCS_OFF_DISP);
            chk(rv[4:0], {1'b1, wc[k]});
            pm.lines(10'h0);
            repeat (3) @(posedge aclk);
            chk(trouble_lamp, 0);
        end
        pm.lines(10'h1E0);
        repeat (3) @(posedge aclk);
        chk(trouble_lamp, 0);
        pm.lines(10'h0);
        for (int k = 0; k < 3; k++)
        begin
            wr(`FCS_OFF_CTRL, 32'h1);
            if (k < 2) pm.fetch(k ? 8'h38 : 8'hFF, k);
            wait_rst(1);
            chk({gauges_off, relays_off}, 2'h3);
            wait_rst(0);
            rd(`FCS_OFF_STATUS);
            chk(rv[3:0], rc[k]);
            chk(trouble_lamp, 1);
            wr(`FCS_OFF_CTRL, 32'h5);
            rd(`FCS_OFF_DISP);
            chk(rv[4:0], {1'b1, rc[k]});
            wr(`FCS_OFF_CTRL, 32'h3);
            repeat (2) @(posedge aclk);
            chk(trouble_lamp, 0);
        end
        wr(`FCS_OFF_CTRL, 32'h25);
        rd(`FCS_OFF_DISP);
        chk(rv[4:0], 5'h12);
        rd(`FCS_OFF_STATUS);
        chk(rv[11], 1);
        s_axi_wstrb <= 4'hE;
        wr(`FCS_OFF_CTRL, 32'h4);
        rd(`FCS_OFF_CTRL);
        chk(rv, 32'h0);
        s_axi_wstrb <= 4'hF;
        wr(`FCS_OFF_CTRL, 32'h9);
        @(posedge aclk);
        chk(def_seen, 1);
        for (int k = 0; k < 3; k++)
        begin
            rst;
            if (k < 2) wr(`FCS_OFF_CTRL, k ? 32'h41 : 32'h11);
            else
            begin
                pm.lines(10'h200);
                repeat (KEY + 5) @(posedge aclk);
                pm.lines(10'h0);
            end
            repeat (3) @(posedge aclk);
            chk({halted, gauges_off, relays_off, trouble_lamp, display_valid, right_display},
                {5'h1F, hc[k]});
            repeat (250) @(posedge aclk);
            chk(halted, 1);
        end
        test_done;
    end
endmodule // fcs_supervisor_tb
